// [core/sleep_glue_pkg.sv]
// constants and carrier types for the sleep-state glue logic
// assumes a single 50 MHz clock; all board inputs arrive asynchronously
//
// Function
// - switch control low only when both high
// - latch cleared by control low or s5 low
// - control rising with s5 high sets latch
// - steady control high holds latch value
// - power-up ramp never sets the latch
// - resume reset released 32 ms after standby
// - release also needs 3.3 V standby present
// - standby loss asserts resume reset at once
// - resume delay self-timed, only at power-on
// - codec reset high: link high, enable low
// - pin function feeds riser logic uninverted
// - gpio output data drives pin and enable
// - polarity inverts both; type picks driver
// - gpio input never drives codec enable
package sleep_glue_pkg;

  // resume reset delay, figure as printed
  localparam int RESUME_DELAY_MS     = 32;
  localparam int CLOCK_KHZ           = 50000;
  localparam int RESUME_DELAY_CYCLES = RESUME_DELAY_MS * CLOCK_KHZ;

  // shared pin function selection
  typedef enum logic [1:0] {
    PIN_CODEC_ENABLE,
    PIN_GPIO_OUTPUT,
    PIN_GPIO_INPUT
  } pin_mode_t;

  // gpio configuration carried as one group
  typedef struct packed {
    pin_mode_t mode;
    logic      data;
    logic      invert;
    logic      open_drain;
  } gpio_cfg_t;

  // synchronised board inputs
  typedef struct packed {
    logic power_good;
    logic s3_n;
    logic s5_n;
    logic stby_5v;
    logic stby_3v;
    logic link_rst_n;
    logic pin_in;
  } board_in_t;

  localparam int BOARD_W = $bits(board_in_t);

endpackage

// [core/sleep_state_glue_logic.sv]
// sleep-state glue: supply switch, latched switch, resume reset, codec reset
// assumes board levels are asynchronous; outputs registered on clock
// the clock must run on standby power, since the resume delay is counted on it
`timescale 1ns/1ns
module sleep_state_glue_logic
  import sleep_glue_pkg::*;
#(
  parameter int RESUME_DELAY = sleep_glue_pkg::RESUME_DELAY_CYCLES
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // sleep and power inputs
  input  wire logic                      psu_power_good,
  input  wire logic                      sleep_s3_n,
  input  wire logic                      sleep_s5_n,
  input  wire logic                      standby_5v_rail,
  input  wire logic                      standby_3v_rail,
  input  wire logic                      audio_link_reset_n,
  // shared pin configuration and pad
  input  wire sleep_glue_pkg::gpio_cfg_t gpio_cfg,
  input  wire logic                      shared_pin_in,
  output logic                           shared_pin_out,
  output logic                           shared_pin_oe_n,
  // supply switch open drain pad
  output logic                           supply_switch_ctl_n_out,
  output logic                           supply_switch_ctl_n_oe_n,
  // reset, latch and gpio input level outputs
  output logic                           latched_supply_switch,
  output logic                           resume_well_reset_n,
  output logic                           codec_down_reset_n,
  output logic                           gpio_input_level
);
  import sleep_glue_pkg::*;

  typedef struct packed {
    logic        sw_drive;
    logic        sw_int_prev;
    logic        armed;
    logic        latched;
    logic [31:0] delay_cnt;
    logic        resume_rst_n;
    logic        codec_rst_n;
    logic        pin_out;
    logic        pin_oe_n;
    logic        gpio_in;
  } glue_state_t;

  // pad data and enable travel together
  typedef struct packed {
    logic out;
    logic oe_n;
  } pad_drive_t;

  // reset image: the previous control reads high, so leaving reset is no edge
  localparam glue_state_t STATE_RESET = '{
    sw_drive:     1'b0,
    sw_int_prev:  1'b1,
    armed:        1'b0,
    latched:      1'b0,
    delay_cnt:    32'h00000000,
    resume_rst_n: 1'b0,
    codec_rst_n:  1'b0,
    pin_out:      1'b1,
    pin_oe_n:     1'b1,
    gpio_in:      1'b0
  };

  board_in_t   raw_in;
  board_in_t   bin;
  glue_state_t state_ff;
  glue_state_t nxt_state;
  logic        sw_int;
  pad_drive_t  pin_pad;
  logic        codec_en_n;

  // the open drain pad pulls low only with power good and s3 high
  function automatic logic switch_pulls_low(input logic power_good, input logic s3_n);
    return power_good & s3_n;
  endfunction

  // the counter saturates at the delay, so it runs once per standby power-on
  function automatic logic delay_expired(input logic [31:0] count);
    return count >= 32'(RESUME_DELAY);
  endfunction

  // gpio drive value after polarity, shared by the pad and the riser logic
  function automatic logic gpio_level(input gpio_cfg_t cfg);
    return cfg.data ^ cfg.invert;
  endfunction

  // latch next value; a clear beats a set, so an s5 low that meets a
  // control edge in one cycle leaves the latch low
  function automatic logic latch_next(
    input logic level,
    input logic level_prev,
    input logic armed,
    input logic s5_n,
    input logic latched
  );
    logic result;
    result = latched;
    if (!level || !s5_n) begin
      result = 1'b0;
    end else if (!level_prev && armed) begin
      result = 1'b1;
    end
    return result;
  endfunction

  // codec-down enable seen by the riser logic for each pin function
  function automatic logic codec_enable_level(
    input gpio_cfg_t cfg,
    input logic      pin_level
  );
    logic level_n;
    case (cfg.mode)
      PIN_CODEC_ENABLE: begin
        level_n = pin_level;
      end
      PIN_GPIO_OUTPUT: begin
        level_n = gpio_level(cfg);
      end
      PIN_GPIO_INPUT: begin
        level_n = 1'b1;
      end
      default: begin
        level_n = 1'b1;
      end
    endcase
    return level_n;
  endfunction

  // pad drive per pin function; only gpio output mode turns the driver on
  function automatic pad_drive_t pad_drive(input gpio_cfg_t cfg);
    pad_drive_t pad;
    pad.out  = 1'b1;
    pad.oe_n = 1'b1;
    if (cfg.mode == PIN_GPIO_OUTPUT) begin
      pad.out  = gpio_level(cfg);
      // open drain only pulls low; push-pull drives both levels
      pad.oe_n = cfg.open_drain ? gpio_level(cfg) : 1'b0;
    end
    return pad;
  endfunction

  // gpio input level as software sees it, usable as a wake source
  function automatic logic wake_level(input gpio_cfg_t cfg, input logic pin_level);
    return pin_level ^ cfg.invert;
  endfunction

  // pack the board levels so one synchroniser handles them all
  assign raw_in = '{
    power_good: psu_power_good,
    s3_n:       sleep_s3_n,
    s5_n:       sleep_s5_n,
    stby_5v:    standby_5v_rail,
    stby_3v:    standby_3v_rail,
    link_rst_n: audio_link_reset_n,
    pin_in:     shared_pin_in
  };

  // every board level is asynchronous, so all pass two flops first
  sync_two_flop #(.WIDTH(BOARD_W)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (bin)
  );

  always_comb begin
    nxt_state = state_ff;
    // open drain pulls low only with power good and s3 high
    nxt_state.sw_drive = switch_pulls_low(bin.power_good, bin.s3_n);
    // floating reads as one, driven low reads as zero
    sw_int = ~nxt_state.sw_drive;
    nxt_state.sw_int_prev = sw_int;

    // the power-up ramp is not an edge: arming needs a seen low first,
    // and reset starts with the previous value high so no edge appears
    if (!sw_int) begin
      nxt_state.armed = 1'b1;
    end
    nxt_state.latched = latch_next(sw_int, state_ff.sw_int_prev, state_ff.armed,
                                   bin.s5_n, state_ff.latched);

    // resume reset: counter stands in for the rc delay, clock only used to
    // count; it restarts only when standby rail comes back
    if (!bin.stby_5v) begin
      nxt_state.delay_cnt    = '0;
      nxt_state.resume_rst_n = 1'b0;
    end else if (!delay_expired(state_ff.delay_cnt)) begin
      nxt_state.delay_cnt    = state_ff.delay_cnt + 32'h00000001;
      nxt_state.resume_rst_n = 1'b0;
    end else begin
      nxt_state.resume_rst_n = bin.stby_3v;
    end

    // shared pin: pad drive and riser enable both follow the pin function
    pin_pad               = pad_drive(gpio_cfg);
    codec_en_n            = codec_enable_level(gpio_cfg, bin.pin_in);
    nxt_state.pin_out     = pin_pad.out;
    nxt_state.pin_oe_n    = pin_pad.oe_n;
    nxt_state.gpio_in     = wake_level(gpio_cfg, bin.pin_in);
    nxt_state.codec_rst_n = bin.link_rst_n & ~codec_en_n;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pad and output assignments straight from flops, except the switch pad data, which is tied low
  assign supply_switch_ctl_n_out  = 1'b0;
  assign supply_switch_ctl_n_oe_n = ~state_ff.sw_drive;
  assign latched_supply_switch    = state_ff.latched;
  assign resume_well_reset_n      = state_ff.resume_rst_n;
  assign codec_down_reset_n       = state_ff.codec_rst_n;
  assign shared_pin_out           = state_ff.pin_out;
  assign shared_pin_oe_n          = state_ff.pin_oe_n;
  assign gpio_input_level         = state_ff.gpio_in;

endmodule

// [core/sync_two_flop.sv]
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the bundle bits are independent levels; no word coherence
`timescale 1ns/1ns
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // first stage only feeds the second stage
  always_comb begin
    nxt_state.first  = async_in;
    nxt_state.second = state_ff.first;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.second;

endmodule

// [testbench/sleep_glue_asserts.sv]
// port checker for the sleep-state glue logic
// assumes outputs lag board inputs by three clock edges
`timescale 1ns/1ns
module sleep_glue_asserts
  import sleep_glue_pkg::*;
(
  input wire logic clock, rst_n, psu_power_good, sleep_s3_n, sleep_s5_n,
  input wire logic standby_5v_rail, standby_3v_rail, audio_link_reset_n,
  input wire sleep_glue_pkg::gpio_cfg_t gpio_cfg,
  input wire logic shared_pin_in, shared_pin_out, shared_pin_oe_n,
  input wire logic supply_switch_ctl_n_out, supply_switch_ctl_n_oe_n,
  input wire logic latched_supply_switch, resume_well_reset_n,
  input wire logic codec_down_reset_n, gpio_input_level
);
  import sleep_glue_pkg::*;
  logic [2:0] up_ff;
  logic       seen_ff;
  logic       rdy;
  logic       oe;
  logic       lat;
  assign rdy = (up_ff == 3'h4);
  assign oe = supply_switch_ctl_n_oe_n;
  assign lat = latched_supply_switch;
  // age since reset, so $past never looks into the sync flush
  always_ff @(posedge clock) begin
    up_ff <= !rst_n ? 3'h0 : (rdy ? up_ff : up_ff + 3'h1);
    seen_ff <= rst_n && (seen_ff || !oe);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  switch_drive_a: assert property (
    rdy |-> oe == !($past(psu_power_good, 3) && $past(sleep_s3_n, 3)))
    else $error("switch control mismatch");
  ctl_clear_a: assert property (!oe |-> !lat)
    else $error("latch not cleared by control");
  s5_clear_a: assert property (rdy && !$past(sleep_s5_n, 3) |-> !lat)
    else $error("latch not cleared by s5");
  latch_set_a: assert property (rdy && $rose(oe) && $past(sleep_s5_n, 3) |-> lat)
    else $error("latch not set");
  latch_hold_a: assert property (
    lat && $past(sleep_s5_n, 2) && !($past(psu_power_good, 2) && $past(sleep_s3_n, 2))
    |=> lat)
    else $error("latch lost");
  ramp_block_a: assert property (!seen_ff |-> !lat)
    else $error("latch set on ramp");
  resume_drop_a: assert property (
    rdy && !$past(standby_5v_rail, 3) |-> !resume_well_reset_n)
    else $error("resume reset late");
  codec_in_a: assert property (
    rdy && $past(gpio_cfg.mode) == PIN_GPIO_INPUT |-> !codec_down_reset_n)
    else $error("codec reset free in input mode");
  cover property ($rose(lat));
  cover property ($fell(lat));
  cover property ($rose(resume_well_reset_n));
  cover property ($rose(codec_down_reset_n));
endmodule
bind sleep_state_glue_logic sleep_glue_asserts sleep_glue_asserts_inst (
  .clock(clock), .rst_n(rst_n), .psu_power_good(psu_power_good),
  .sleep_s3_n(sleep_s3_n), .sleep_s5_n(sleep_s5_n), .standby_5v_rail(standby_5v_rail),
  .standby_3v_rail(standby_3v_rail), .audio_link_reset_n(audio_link_reset_n),
  .gpio_cfg(gpio_cfg), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
  .shared_pin_oe_n(shared_pin_oe_n), .supply_switch_ctl_n_out(supply_switch_ctl_n_out),
  .supply_switch_ctl_n_oe_n(supply_switch_ctl_n_oe_n),
  .latched_supply_switch(latched_supply_switch), .resume_well_reset_n(resume_well_reset_n),
  .codec_down_reset_n(codec_down_reset_n), .gpio_input_level(gpio_input_level));

// [testbench/sleep_partner.sv]
// model of the south bridge sleep outputs and the supply rails
// assumes the bench calls its tasks at falling edges
`timescale 1ns/1ns
module sleep_partner #(
  parameter int MS = 50
) (
  input  wire logic clock,
  output logic      power_good,
  output logic      s3_n,
  output logic      s5_n,
  output logic      stby_5v,
  output logic      stby_3v
);
  initial {power_good, s3_n, s5_n, stby_5v, stby_3v} = 5'h00;
  // a millisecond is scaled down to MS cycles, or the run grows far too long
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rails(input logic v5, input logic v3);
    {stby_5v, stby_3v} = {v5, v3};
  endtask
  task automatic drive(input logic pg, input logic s3);
    {power_good, s3_n} = {pg, s3};
  endtask
  // s5 held low first, switch control only after s5 has been high a while
  task automatic power_up();
    idle(25 * MS);
    s5_n = 1'b1;
    idle(MS);
    drive(1'b1, 1'b1);
  endtask
  // 32 us from s3 dropping, so s5 falls over 30 us after the switch lets go
  task automatic power_down();
    s3_n = 1'b0;
    idle(1600);
    s5_n = 1'b0;
    power_good = 1'b0;
  endtask
  task automatic resume();
    idle(MS);
    s5_n = 1'b1;
    idle(MS);
    drive(1'b1, 1'b1);
  endtask
endmodule

// [testbench/test_sleep_state_glue_logic.sv]
// self-checking bench for the sleep-state glue logic
// assumes a 20-cycle resume delay and inputs moved at falling edges
`timescale 1ns/1ns
module test_sleep_state_glue_logic;
  import sleep_glue_pkg::*;
  localparam int DLY = 20;
  logic clock, rst_n, link_n, pin_in, en;
  logic pg, s3_n, s5_n, v5, v3, p_out, p_oe_n, sw_out, sw_oe_n, lat, rsm_n, cdc_n, gin;
  gpio_cfg_t cfg;
  int miscompares = 0;
  int n_tests = 0;
  sleep_partner #(.MS(50)) sleep_partner_inst (.clock(clock), .power_good(pg),
    .s3_n(s3_n), .s5_n(s5_n), .stby_5v(v5), .stby_3v(v3));
  sleep_state_glue_logic #(.RESUME_DELAY(DLY)) sleep_state_glue_logic_inst (
    .clock(clock), .rst_n(rst_n), .psu_power_good(pg), .sleep_s3_n(s3_n),
    .sleep_s5_n(s5_n), .standby_5v_rail(v5), .standby_3v_rail(v3),
    .audio_link_reset_n(link_n), .gpio_cfg(cfg), .shared_pin_in(pin_in),
    .shared_pin_out(p_out), .shared_pin_oe_n(p_oe_n), .supply_switch_ctl_n_out(sw_out),
    .supply_switch_ctl_n_oe_n(sw_oe_n), .latched_supply_switch(lat),
    .resume_well_reset_n(rsm_n), .codec_down_reset_n(cdc_n), .gpio_input_level(gin));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // about 3500 cycles of tests; a hang is cut well beyond that
  initial begin
    #(20 * 8000);
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, link_n, pin_in} = 3'h2;
    cfg = '{PIN_GPIO_INPUT, 1'b0, 1'b0, 1'b0};
    repeat (6) @(posedge clock);
    idle(1);
    rst_n = 1'b1;
    // resume reset: delay, missing 3.3 V, brown-out
    sleep_partner_inst.rails(1'b1, 1'b0);
    idle(DLY + 8);
    check("resume held", 1'b0, rsm_n);
    sleep_partner_inst.rails(1'b1, 1'b1);
    idle(5);
    check("resume free", 1'b1, rsm_n);
    sleep_partner_inst.rails(1'b0, 1'b1);
    idle(4);
    check("brown out", 1'b0, rsm_n);
    sleep_partner_inst.rails(1'b1, 1'b1);
    idle(DLY - 4);
    check("resume early", 1'b0, rsm_n);
    idle(16);
    check("resume again", 1'b1, rsm_n);
    $display("test resume done");
    // supply switch and its latch through a full sleep cycle
    sleep_partner_inst.power_up();
    idle(4);
    check("switch on", 1'b0, sw_oe_n);
    check("ramp latch", 1'b0, lat);
    fork
      sleep_partner_inst.power_down();
      begin
        idle(6);
        check("latch set", 1'b1, lat);
      end
    join
    idle(4);
    check("latch cleared", 1'b0, lat);
    fork
      sleep_partner_inst.resume();
      begin
        idle(56);
        check("latch held", 1'b0, lat);
      end
    join
    idle(4);
    check("switch back", 1'b0, sw_oe_n);
    check("latch after resume", 1'b0, lat);
    for (int i = 0; i < 4; i++) begin
      sleep_partner_inst.drive(i[1], i[0]);
      idle(4);
      check("switch table", !(i[1] && i[0]), sw_oe_n);
      check("latch table", i != 3, lat);
      check("switch data", 1'b0, sw_out);
    end
    $display("test switch done");
    // codec reset over every pin mode, data, polarity, driver and link level
    for (int i = 0; i < 96; i++) begin
      cfg = '{pin_mode_t'(i / 32), i[0], i[1], i[2]};
      {link_n, pin_in} = {i[4], i[3]};
      idle(4);
      en = cfg.mode == PIN_CODEC_ENABLE ? pin_in
         : cfg.mode == PIN_GPIO_OUTPUT ? cfg.data ^ cfg.invert : 1'b1;
      check("codec reset", link_n & ~en, cdc_n);
      if (cfg.mode == PIN_GPIO_INPUT) begin
        check("wake level", pin_in ^ cfg.invert, gin);
      end
      if (cfg.mode == PIN_GPIO_OUTPUT) begin
        check("pin enable", cfg.open_drain & (cfg.data ^ cfg.invert), p_oe_n);
      end else begin
        check("pin released", 1'b1, p_oe_n);
      end
      if (cfg.mode == PIN_GPIO_OUTPUT && !cfg.open_drain) begin
        check("pin data", cfg.data ^ cfg.invert, p_out);
      end
    end
    $display("test codec done");
    conclude();
  end
endmodule
